// ===== hdl/color_matrix_defines.svh
// offsets, field positions, reset values and timing counts of the colour transform
// assumes a 32-bit plain register port with byte offsets in 8 bits
`ifndef COLOR_MATRIX_DEFINES_SVH
`define COLOR_MATRIX_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CMT_ADDR_CTRL      8'h00
`define CMT_ADDR_PRESET    8'h04
`define CMT_ADDR_COEF_SEL  8'h08
`define CMT_ADDR_COEF_VAL  8'h0c
`define CMT_ADDR_SAT       8'h10
`define CMT_ADDR_WB        8'h14
`define CMT_ADDR_STATUS    8'h18

// ----------------------------------------
// control fields
// ----------------------------------------
`define CMT_CTRL_PIPE_ON   0
`define CMT_CTRL_INST_SEL  1
`define CMT_CTRL_INST_ON   2
`define CMT_CTRL_BOOST_ON  3
`define CMT_CTRL_YUV_FMT   4

// ----------------------------------------
// reset values and fixed figures
// ----------------------------------------
`define CMT_COEF_ONE       16'h1000
`define CMT_COEF_FRAC      12
`define CMT_NUM_COEF       12
`define CMT_SAT_RESET      12'h100
`define CMT_SAT_FRAC       8
`define CMT_WB_RESET       16'h1000
`define CMT_MAT_LAT        2
// per preset {red gain, blue gain}, preset 0 in the low word; arbitrary calibration
`define CMT_PRESET_RB_GAIN {32'h1200_1000, 32'h1000_1300, 32'h1100_1080, 32'h1080_1100, \
                            32'h1000_1200, 32'h1100_1000, 32'h1000_1000}
// per preset {blue ratio, red ratio}; arbitrary calibration
`define CMT_PRESET_WB      {32'h1a00_1600, 32'h1000_2200, 32'h1800_1800, 32'h1600_1a00, \
                            32'h1000_2000, 32'h2000_1000, 32'h1800_1800}

// ----------------------------------------
// luma/chroma matrix, q3.12 gains, offsets in 8-bit pixel units
// ----------------------------------------
`define CMT_YUV_G00        16'h04c9
`define CMT_YUV_G01        16'h0964
`define CMT_YUV_G02        16'h01d3
`define CMT_YUV_G10        16'hfd4d
`define CMT_YUV_G11        16'hfab3
`define CMT_YUV_G12        16'h0800
`define CMT_YUV_G20        16'h0800
`define CMT_YUV_G21        16'hf94d
`define CMT_YUV_G22        16'hfeb3
`define CMT_YUV_O0         16'h0000
`define CMT_YUV_O1         16'h0080
`define CMT_YUV_O2         16'h0080

`endif

// ===== hdl/color_matrix_pkg.sv
// types shared by the colour transform modules
// assumes the defines header is included by each user
package color_matrix_pkg;
	typedef enum logic {
		INST_NATIVE_TO_STD = 1'b0,
		INST_LUMA_CHROMA   = 1'b1
	} instance_e;

	typedef enum logic [2:0] {
		PRESET_GENERAL   = 3'b000,
		PRESET_WARM_FL   = 3'b001,
		PRESET_COOL_FL   = 3'b010,
		PRESET_DAYLIGHT  = 3'b011,
		PRESET_CLOUDY    = 3'b100,
		PRESET_TUNGSTEN  = 3'b101,
		PRESET_SHADE     = 3'b110,
		PRESET_CUSTOM    = 3'b111
	} preset_e;

	typedef logic [15:0] coeff_t;

	// saturate a signed value into 0 .. 2**w-1
	function automatic logic [15:0] clamp_pix(input logic signed [31:0] v, input int w);
		logic signed [31:0] top;
		top = (32'sd1 <<< w) - 32'sd1;
		if (v < 0)
			clamp_pix = 16'h0000;
		else if (v > top)
			clamp_pix = top[15:0];
		else
			clamp_pix = v[15:0];
	endfunction
endpackage

// ===== hdl/color_matrix_transform.sv
// colour transform top: correction matrix, gamma hand-off, saturation, luma/chroma matrix
// assumes pixel stream and register port on clk_i; gamma stage returns in order
// Functional notes
// - output is weighted sum plus offset
// - three channels, row i and offset i
// - two instances chosen by instance selector
// - correction enable applies or bypasses matrix
// - luma/chroma after correction and gamma
// - luma/chroma active only for yuv format
// - luma/chroma enable read-only, follows format
// - correction matrix loaded from illuminant preset
// - reads return coefficient currently in use
// - index selects gain or offset
// - non-custom preset choice loads red/blue ratios
// - saturation applied only when enabled
// - controls work only with pipeline on
// - twelve coefficients per instance
`timescale 1ns/100ps
`include "color_matrix_defines.svh"

module color_matrix_transform #(
	parameter int PIX_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output logic [31:0]            reg_rdata_o,
	input  wire logic              frame_start_i,
	input  wire logic              pix_valid_i,
	input  wire logic [PIX_W-1:0]  pix_r_i,
	input  wire logic [PIX_W-1:0]  pix_g_i,
	input  wire logic [PIX_W-1:0]  pix_b_i,
	output logic                   gam_valid_o,
	output logic [PIX_W-1:0]       gam_r_o,
	output logic [PIX_W-1:0]       gam_g_o,
	output logic [PIX_W-1:0]       gam_b_o,
	input  wire logic              gam_valid_i,
	input  wire logic [PIX_W-1:0]  gam_r_i,
	input  wire logic [PIX_W-1:0]  gam_g_i,
	input  wire logic [PIX_W-1:0]  gam_b_i,
	output logic                   out_valid_o,
	output logic [PIX_W-1:0]       out_c0_o,
	output logic [PIX_W-1:0]       out_c1_o,
	output logic [PIX_W-1:0]       out_c2_o,
	output logic [15:0]            red_wb_ratio_o,
	output logic [15:0]            blue_wb_ratio_o
);
	// ----------------------------------------
	// lookup functions
	// ----------------------------------------
	function automatic color_matrix_pkg::coeff_t preset_coeff(input logic [2:0] p, input logic [3:0] idx);
		logic [223:0] tab;
		logic [31:0]  rb;
		tab = `CMT_PRESET_RB_GAIN;
		rb  = tab[32*int'(p) +: 32];
		case (idx)
			4'd0:    preset_coeff = rb[31:16];
			4'd4:    preset_coeff = `CMT_COEF_ONE;
			4'd8:    preset_coeff = rb[15:0];
			default: preset_coeff = 16'h0000;
		endcase
	endfunction

	function automatic color_matrix_pkg::coeff_t yuv_coeff(input logic [3:0] idx);
		case (idx)
			4'd0:    yuv_coeff = `CMT_YUV_G00;
			4'd1:    yuv_coeff = `CMT_YUV_G01;
			4'd2:    yuv_coeff = `CMT_YUV_G02;
			4'd3:    yuv_coeff = `CMT_YUV_G10;
			4'd4:    yuv_coeff = `CMT_YUV_G11;
			4'd5:    yuv_coeff = `CMT_YUV_G12;
			4'd6:    yuv_coeff = `CMT_YUV_G20;
			4'd7:    yuv_coeff = `CMT_YUV_G21;
			4'd8:    yuv_coeff = `CMT_YUV_G22;
			4'd9:    yuv_coeff = `CMT_YUV_O0;
			4'd10:   yuv_coeff = `CMT_YUV_O1;
			4'd11:   yuv_coeff = `CMT_YUV_O2;
			default: yuv_coeff = 16'h0000;
		endcase
	endfunction

	function automatic logic [15:0] wb_tab(input logic [2:0] p, input logic blue);
		logic [223:0] tab;
		logic [31:0]  w;
		tab = `CMT_PRESET_WB;
		w   = tab[32*int'(p) +: 32];
		wb_tab = blue ? w[31:16] : w[15:0];
	endfunction

	// ----------------------------------------
	// software-visible state
	// ----------------------------------------
	logic                          pipe_on_reg;
	color_matrix_pkg::instance_e   inst_sel_reg;
	logic                          cor_on_reg;
	logic                          boost_on_reg;
	logic                          yuv_fmt_reg;
	color_matrix_pkg::preset_e     preset_reg;
	logic [3:0]                    coef_idx_reg;
	logic [11:0]                   sat_reg;
	color_matrix_pkg::coeff_t      user_coef_reg [12];
	logic [31:0]                   rdata_next;

	// ----------------------------------------
	// state in use by the datapath, swapped at frame start
	// ----------------------------------------
	logic                          act_cor_on_reg;
	logic                          act_yuv_on_reg;
	logic                          act_boost_on_reg;
	logic [11:0]                   act_sat_reg;
	color_matrix_pkg::preset_e     act_preset_reg;
	color_matrix_pkg::coeff_t      act_coef_reg [12];
	logic [12*16-1:0]              cor_flat;
	logic [12*16-1:0]              yuv_flat;

	logic wr_ctrl;
	logic wr_gated;
	logic coef_wr_ok;

	assign wr_ctrl    = reg_wr_i && (reg_addr_i == `CMT_ADDR_CTRL);
	assign wr_gated   = reg_wr_i && pipe_on_reg;
	// user values only take hold under the custom preset on the correction instance
	assign coef_wr_ok = wr_gated && (reg_addr_i == `CMT_ADDR_COEF_VAL)
	                    && (inst_sel_reg == color_matrix_pkg::INST_NATIVE_TO_STD)
	                    && (preset_reg == color_matrix_pkg::PRESET_CUSTOM)
	                    && (coef_idx_reg < 4'(`CMT_NUM_COEF));

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pipe_on_reg  <= 1'b0;
			inst_sel_reg <= color_matrix_pkg::INST_NATIVE_TO_STD;
			cor_on_reg   <= 1'b0;
			boost_on_reg <= 1'b0;
			yuv_fmt_reg  <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			pipe_on_reg <= reg_wdata_i[`CMT_CTRL_PIPE_ON];
			if (pipe_on_reg)
			begin
				inst_sel_reg <= color_matrix_pkg::instance_e'(reg_wdata_i[`CMT_CTRL_INST_SEL]);
				boost_on_reg <= reg_wdata_i[`CMT_CTRL_BOOST_ON];
				yuv_fmt_reg  <= reg_wdata_i[`CMT_CTRL_YUV_FMT];
				// enable bit lands on the correction instance only if it was selected before this write
				if (inst_sel_reg == color_matrix_pkg::INST_NATIVE_TO_STD)
					cor_on_reg <= reg_wdata_i[`CMT_CTRL_INST_ON];
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			preset_reg      <= color_matrix_pkg::PRESET_GENERAL;
			red_wb_ratio_o  <= `CMT_WB_RESET;
			blue_wb_ratio_o <= `CMT_WB_RESET;
		end
		else if (wr_gated && reg_addr_i == `CMT_ADDR_PRESET)
		begin
			preset_reg <= color_matrix_pkg::preset_e'(reg_wdata_i[2:0]);
			if (reg_wdata_i[2:0] != color_matrix_pkg::PRESET_CUSTOM)
			begin
				red_wb_ratio_o  <= wb_tab(reg_wdata_i[2:0], 1'b0);
				blue_wb_ratio_o <= wb_tab(reg_wdata_i[2:0], 1'b1);
			end
		end
		else if (wr_gated && reg_addr_i == `CMT_ADDR_WB)
		begin
			// white balance may overwrite the preset ratios at any time while the pipeline is on
			red_wb_ratio_o  <= reg_wdata_i[15:0];
			blue_wb_ratio_o <= reg_wdata_i[31:16];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			coef_idx_reg <= 4'h0;
			sat_reg      <= `CMT_SAT_RESET;
		end
		else
		begin
			if (wr_gated && reg_addr_i == `CMT_ADDR_COEF_SEL)
				coef_idx_reg <= reg_wdata_i[3:0];
			if (wr_gated && reg_addr_i == `CMT_ADDR_SAT)
				sat_reg <= reg_wdata_i[11:0];
		end
	end

	// user matrix, stored bit-exact as written
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < 12; i++)
				user_coef_reg[i] <= preset_coeff(3'b000, 4'(i));
		end
		else if (coef_wr_ok)
			user_coef_reg[coef_idx_reg] <= reg_wdata_i[15:0];
	end

	// ----------------------------------------
	// frame-boundary swap
	// ----------------------------------------
	// swapping mid-frame would tear the picture, so changes wait for frame start
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			act_cor_on_reg   <= 1'b0;
			act_yuv_on_reg   <= 1'b0;
			act_boost_on_reg <= 1'b0;
			act_sat_reg      <= `CMT_SAT_RESET;
			act_preset_reg   <= color_matrix_pkg::PRESET_GENERAL;
			for (int i = 0; i < 12; i++)
				act_coef_reg[i] <= 16'h0000;
		end
		else if (frame_start_i)
		begin
			act_cor_on_reg   <= cor_on_reg && pipe_on_reg;
			act_yuv_on_reg   <= yuv_fmt_reg && pipe_on_reg;
			act_boost_on_reg <= boost_on_reg && pipe_on_reg;
			act_sat_reg      <= sat_reg;
			act_preset_reg   <= preset_reg;
			for (int i = 0; i < 12; i++)
			begin
				if (preset_reg == color_matrix_pkg::PRESET_CUSTOM)
					act_coef_reg[i] <= user_coef_reg[i];
				else
					act_coef_reg[i] <= preset_coeff(preset_reg, 4'(i));
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < 12; i++)
		begin
			cor_flat[16*i +: 16] = act_coef_reg[i];
			yuv_flat[16*i +: 16] = yuv_coeff(4'(i));
		end
	end

	// ----------------------------------------
	// register read, data one cycle after strobe
	// ----------------------------------------
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (reg_rd_i && reg_addr_i == `CMT_ADDR_CTRL)
		begin
			rdata_next[`CMT_CTRL_PIPE_ON] = pipe_on_reg;
			if (pipe_on_reg)
			begin
				rdata_next[`CMT_CTRL_INST_SEL] = inst_sel_reg;
				rdata_next[`CMT_CTRL_INST_ON]  = (inst_sel_reg == color_matrix_pkg::INST_LUMA_CHROMA)
				                                 ? yuv_fmt_reg : cor_on_reg;
				rdata_next[`CMT_CTRL_BOOST_ON] = boost_on_reg;
				rdata_next[`CMT_CTRL_YUV_FMT]  = yuv_fmt_reg;
			end
		end
		else if (reg_rd_i && pipe_on_reg)
		begin
			case (reg_addr_i)
				`CMT_ADDR_PRESET:   rdata_next[2:0] = preset_reg;
				`CMT_ADDR_COEF_SEL: rdata_next[3:0] = coef_idx_reg;
				`CMT_ADDR_COEF_VAL:
				begin
					if (coef_idx_reg >= 4'(`CMT_NUM_COEF))
						rdata_next = 32'h0000_0000;
					else if (inst_sel_reg == color_matrix_pkg::INST_LUMA_CHROMA)
						rdata_next[15:0] = yuv_coeff(coef_idx_reg);
					else
						rdata_next[15:0] = act_coef_reg[coef_idx_reg];
				end
				`CMT_ADDR_SAT:      rdata_next[11:0] = sat_reg;
				`CMT_ADDR_WB:       rdata_next = {blue_wb_ratio_o, red_wb_ratio_o};
				`CMT_ADDR_STATUS:   rdata_next[6:0] = {act_preset_reg, 1'b0, act_boost_on_reg,
				                                       act_yuv_on_reg, act_cor_on_reg};
				default:            rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			reg_rdata_o <= 32'h0000_0000;
		else
			reg_rdata_o <= rdata_next;
	end

	// ----------------------------------------
	// correction matrix, result goes to gamma
	// ----------------------------------------
	matrix3x3_unit #(
		.PIX_W (PIX_W)
	) u_cor (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.enable_i    (act_cor_on_reg),
		.coeff_i     (cor_flat),
		.in_valid_i  (pix_valid_i),
		.in_r_i      (pix_r_i),
		.in_g_i      (pix_g_i),
		.in_b_i      (pix_b_i),
		.out_valid_o (gam_valid_o),
		.out_c0_o    (gam_r_o),
		.out_c1_o    (gam_g_o),
		.out_c2_o    (gam_b_o)
	);

	// ----------------------------------------
	// saturation on gamma-corrected pixels
	// ----------------------------------------
	logic                       sat_vld_reg;
	logic [PIX_W-1:0]           luma_reg;
	logic signed [PIX_W:0]      diff_reg [3];
	logic [PIX_W-1:0]           raw_reg [3];
	logic                       sat_out_vld_reg;
	logic [PIX_W-1:0]           sat_pix_reg [3];
	logic [PIX_W+1:0]           luma_sum;
	logic [PIX_W-1:0]           gam_pix [3];

	assign gam_pix[0] = gam_r_i;
	assign gam_pix[1] = gam_g_i;
	assign gam_pix[2] = gam_b_i;
	// cheap luma estimate, good enough for a vividness control
	assign luma_sum = {2'b00, gam_r_i} + {1'b0, gam_g_i, 1'b0} + {2'b00, gam_b_i};

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sat_vld_reg     <= 1'b0;
			luma_reg        <= '0;
			sat_out_vld_reg <= 1'b0;
			for (int j = 0; j < 3; j++)
			begin
				diff_reg[j]    <= '0;
				raw_reg[j]     <= '0;
				sat_pix_reg[j] <= '0;
			end
		end
		else
		begin
			sat_vld_reg     <= gam_valid_i;
			luma_reg        <= luma_sum[PIX_W+1:2];
			sat_out_vld_reg <= sat_vld_reg;
			for (int j = 0; j < 3; j++)
			begin
				diff_reg[j] <= $signed({1'b0, gam_pix[j]}) - $signed({1'b0, luma_sum[PIX_W+1:2]});
				raw_reg[j]  <= gam_pix[j];
				if (act_boost_on_reg)
					sat_pix_reg[j] <= PIX_W'(color_matrix_pkg::clamp_pix(32'($signed({1'b0, luma_reg}))
					                  + ((32'(diff_reg[j]) * $signed({20'h00000, act_sat_reg})) >>> `CMT_SAT_FRAC),
					                  PIX_W));
				else
					sat_pix_reg[j] <= raw_reg[j];
			end
		end
	end

	// ----------------------------------------
	// luma/chroma matrix, last in the chain
	// ----------------------------------------
	matrix3x3_unit #(
		.PIX_W (PIX_W)
	) u_yuv (
		.clk_i       (clk_i),
		.sys_rst_i   (sys_rst_i),
		.enable_i    (act_yuv_on_reg),
		.coeff_i     (yuv_flat),
		.in_valid_i  (sat_out_vld_reg),
		.in_r_i      (sat_pix_reg[0]),
		.in_g_i      (sat_pix_reg[1]),
		.in_b_i      (sat_pix_reg[2]),
		.out_valid_o (out_valid_o),
		.out_c0_o    (out_c0_o),
		.out_c1_o    (out_c1_o),
		.out_c2_o    (out_c2_o)
	);
endmodule

// ===== hdl/matrix3x3_unit.sv
// one 3x3 gain matrix plus offset triplet, two pipeline stages
// assumes coefficients are steady within a frame; bypass keeps the same latency
`timescale 1ns/100ps
`include "color_matrix_defines.svh"

module matrix3x3_unit #(
	parameter int PIX_W  = 8,
	parameter int COEF_W = 16,
	parameter int FRAC   = `CMT_COEF_FRAC
) (
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   enable_i,
	input  wire logic [12*COEF_W-1:0]   coeff_i,
	input  wire logic                   in_valid_i,
	input  wire logic [PIX_W-1:0]       in_r_i,
	input  wire logic [PIX_W-1:0]       in_g_i,
	input  wire logic [PIX_W-1:0]       in_b_i,
	output logic                        out_valid_o,
	output logic [PIX_W-1:0]            out_c0_o,
	output logic [PIX_W-1:0]            out_c1_o,
	output logic [PIX_W-1:0]            out_c2_o
);
	localparam int PW = PIX_W + COEF_W + 1;
	localparam int SW = PW + 2;

	logic signed [PW-1:0] prod_reg [9];
	logic [PIX_W-1:0]     byp_reg [3];
	logic                 en_reg;
	logic                 vld_reg;
	logic [PIX_W-1:0]     pix [3];
	logic [PIX_W-1:0]     res [3];

	assign pix[0] = in_r_i;
	assign pix[1] = in_g_i;
	assign pix[2] = in_b_i;

	// ----------------------------------------
	// stage 1: nine products
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < 9; i++)
				prod_reg[i] <= '0;
			for (int j = 0; j < 3; j++)
				byp_reg[j] <= '0;
			en_reg  <= 1'b0;
			vld_reg <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < 9; i++)
				prod_reg[i] <= $signed(coeff_i[i*COEF_W +: COEF_W]) * $signed({1'b0, pix[i % 3]});
			for (int j = 0; j < 3; j++)
				byp_reg[j] <= pix[j];
			en_reg  <= enable_i;
			vld_reg <= in_valid_i;
		end
	end

	// ----------------------------------------
	// stage 2: row sums, offset, clamp
	// ----------------------------------------
	always_comb
	begin
		logic signed [SW-1:0] acc;
		acc = '0;
		for (int r = 0; r < 3; r++)
		begin
			acc = SW'(prod_reg[3*r]) + SW'(prod_reg[3*r+1]) + SW'(prod_reg[3*r+2]);
			acc = (acc >>> FRAC) + SW'($signed(coeff_i[(9+r)*COEF_W +: COEF_W]));
			res[r] = en_reg ? PIX_W'(color_matrix_pkg::clamp_pix(32'(acc), PIX_W)) : byp_reg[r];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			out_valid_o <= 1'b0;
			out_c0_o    <= '0;
			out_c1_o    <= '0;
			out_c2_o    <= '0;
		end
		else
		begin
			out_valid_o <= vld_reg;
			out_c0_o    <= res[0];
			out_c1_o    <= res[1];
			out_c2_o    <= res[2];
		end
	end
endmodule

// ===== verif/cmt_monitor.sv
// checker on the colour transform ports: register port, stream timing, wb ratios
// assumes binding into color_matrix_transform; one clock domain
`timescale 1ns/100ps
`include "color_matrix_defines.svh"

module cmt_monitor (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        pix_valid_i,
	input wire logic        gam_valid_o,
	input wire logic        gam_valid_i,
	input wire logic        out_valid_o,
	input wire logic [15:0] red_wb_ratio_o,
	input wire logic [15:0] blue_wb_ratio_o
);
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	localparam logic [223:0] WB_TAB = `CMT_PRESET_WB;
	logic pipe_reg;
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
			pipe_reg <= 1'b0;
		else if (reg_wr_i && reg_addr_i == `CMT_ADDR_CTRL)
			pipe_reg <= reg_wdata_i[0];

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside read slot");
	a_pipe_off_read: assert property (reg_rd_i && !pipe_reg |=> reg_rdata_o == 32'h0)
		else $error("read with pipeline off not zero");
	a_gam_latency: assert property (pix_valid_i |-> ##2 gam_valid_o)
		else $error("gamma hand-off late");
	a_gam_cause: assert property (gam_valid_o |-> $past(pix_valid_i, 2))
		else $error("gamma hand-off without pixel");
	a_out_latency: assert property (gam_valid_i |-> ##4 out_valid_o)
		else $error("output pixel late");
	a_wb_hold: assert property (!$past(reg_wr_i) |-> $stable({blue_wb_ratio_o, red_wb_ratio_o}))
		else $error("wb ratios moved without write");
	a_wb_write: assert property (reg_wr_i && pipe_reg && reg_addr_i == `CMT_ADDR_WB
		|=> {blue_wb_ratio_o, red_wb_ratio_o} == $past(reg_wdata_i)) else $error("wb write lost");
	a_preset_wb: assert property (reg_wr_i && pipe_reg && reg_addr_i == `CMT_ADDR_PRESET
		&& reg_wdata_i[2:0] != 3'h7 |=> {blue_wb_ratio_o, red_wb_ratio_o} == WB_TAB[$past(reg_wdata_i[2:0]) * 32 +: 32])
		else $error("preset wb ratios wrong");

	c_coef_read: cover property (reg_rd_i && reg_addr_i == `CMT_ADDR_COEF_VAL);
	c_preset: cover property (reg_wr_i && pipe_reg && reg_addr_i == `CMT_ADDR_PRESET);
	c_out: cover property (out_valid_o);
endmodule

bind color_matrix_transform cmt_monitor u_mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.pix_valid_i(pix_valid_i), .gam_valid_o(gam_valid_o), .gam_valid_i(gam_valid_i), .out_valid_o(out_valid_o),
	.red_wb_ratio_o(red_wb_ratio_o), .blue_wb_ratio_o(blue_wb_ratio_o));

// ===== verif/color_matrix_transform_tb_top.sv
// self-checking bench for the colour transform with a gamma stage model
// assumes 8-bit pixels and the register map of the defines header
`timescale 1ns/100ps
`include "color_matrix_defines.svh"

module color_matrix_transform_tb_top;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        frame_start_i = 1'b0;
	logic        pix_valid_i = 1'b0;
	logic [23:0] pix_i = 24'h0;
	logic        slow = 1'b0;
	logic [31:0] reg_rdata_o;
	logic        gam_valid_o;
	logic        gam_valid_i;
	logic        out_valid_o;
	logic [23:0] gam_o;
	logic [23:0] gam_i;
	logic [23:0] out_o;
	logic [15:0] red_wb_ratio_o;
	logic [15:0] blue_wb_ratio_o;
	logic [31:0] rd_val;
	logic [23:0] exp_q [$];
	int          mismatches = 0;
	int          comparisons = 0;
	// r g b, corrected c0 c1 c2, luma
	logic [55:0] rows [4] = '{56'h10_20_30_28_20_40_20, 56'hff_ff_ff_ff_ff_ff_ff, 56'h00_00_08_10_00_00_02,
		56'h81_40_70_70_40_c0_5c};
	logic [15:0] coef [12] = '{16'h0800, 16'h0800, 16'h0000, 16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h0000,
		16'h2000, 16'h0010, 16'h0000, 16'hffe0};
	logic [31:0] ctl [3] = '{32'h5, 32'h1, 32'h19};

	always #4 clk_i = ~clk_i;

	color_matrix_transform uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.frame_start_i(frame_start_i), .pix_valid_i(pix_valid_i), .pix_r_i(pix_i[23:16]), .pix_g_i(pix_i[15:8]),
		.pix_b_i(pix_i[7:0]), .gam_valid_o(gam_valid_o), .gam_r_o(gam_o[23:16]), .gam_g_o(gam_o[15:8]),
		.gam_b_o(gam_o[7:0]), .gam_valid_i(gam_valid_i), .gam_r_i(gam_i[23:16]), .gam_g_i(gam_i[15:8]),
		.gam_b_i(gam_i[7:0]), .out_valid_o(out_valid_o), .out_c0_o(out_o[23:16]), .out_c1_o(out_o[15:8]),
		.out_c2_o(out_o[7:0]), .red_wb_ratio_o(red_wb_ratio_o), .blue_wb_ratio_o(blue_wb_ratio_o));

	gamma_stage_model u_gamma (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow), .valid_i(gam_valid_o),
		.pix_i(gam_o), .valid_o(gam_valid_i), .pix_o(gam_i));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rd_val = reg_rdata_o;
	endtask

	task automatic frame();
		@(posedge clk_i);
		frame_start_i <= 1'b1;
		@(posedge clk_i);
		frame_start_i <= 1'b0;
	endtask

	always @(posedge clk_i)
		if (out_valid_o === 1'b1)
		begin
			check("pixel", {8'h00, out_o}, exp_q.size() != 0 ? {8'h00, exp_q[0]} : 32'hffffffff);
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end

	initial
	begin
		#100000;
		mismatches++;
		complete_run();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int k;
		int m;
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		#1 check("wb reset", {blue_wb_ratio_o, red_wb_ratio_o}, 32'h1000_1000);
		reg_write(`CMT_ADDR_PRESET, 32'h7);
		reg_read(`CMT_ADDR_PRESET);
		check("preset pipe off", rd_val, 32'h0);
		reg_write(`CMT_ADDR_CTRL, 32'h1);
		reg_write(`CMT_ADDR_PRESET, 32'h7);
		reg_write(`CMT_ADDR_SAT, 32'h0);
		for (k = 0; k < 12; k++)
		begin
			reg_write(`CMT_ADDR_COEF_SEL, 32'(k));
			reg_write(`CMT_ADDR_COEF_VAL, {16'h0000, coef[k]});
		end
		frame();
		reg_read(`CMT_ADDR_COEF_VAL);
		check("offset2", rd_val, 32'h0000_ffe0);
		reg_read(8'h1c);
		check("unmapped", rd_val, 32'h0);
		// corrected, bypassed with slow gamma, then grey with zero saturation into luma/chroma
		for (m = 0; m < 3; m++)
		begin
			slow <= (m == 1);
			reg_write(`CMT_ADDR_CTRL, ctl[m]);
			frame();
			for (k = 0; k < 4; k++)
			begin
				@(posedge clk_i);
				pix_valid_i <= 1'b1;
				pix_i <= rows[k][55:32];
				exp_q.push_back(m == 0 ? rows[k][31:8] : (m == 1 ? rows[k][55:32] : {rows[k][7:0], 16'h8080}));
			end
			@(posedge clk_i);
			pix_valid_i <= 1'b0;
			pix_i <= ~pix_i;
			for (k = 0; k < 40 && exp_q.size() != 0; k++)
				@(posedge clk_i);
			check("drain", 32'(exp_q.size()), 32'h0);
		end
		reg_write(`CMT_ADDR_COEF_SEL, 32'h0);
		reg_write(`CMT_ADDR_COEF_VAL, 32'h1000);
		reg_read(`CMT_ADDR_COEF_VAL);
		check("coef before frame", rd_val, 32'h0800);
		frame();
		reg_read(`CMT_ADDR_COEF_VAL);
		check("coef after frame", rd_val, 32'h1000);
		// enable of the luma/chroma instance cannot be written
		reg_write(`CMT_ADDR_CTRL, 32'h3);
		reg_write(`CMT_ADDR_CTRL, 32'h7);
		reg_read(`CMT_ADDR_CTRL);
		check("yuv enable", rd_val, 32'h3);
		reg_write(`CMT_ADDR_COEF_VAL, 32'h1234);
		reg_read(`CMT_ADDR_COEF_VAL);
		check("yuv g00", rd_val, {16'h0000, `CMT_YUV_G00});
		reg_write(`CMT_ADDR_COEF_SEL, 32'ha);
		reg_read(`CMT_ADDR_COEF_VAL);
		check("yuv o1", rd_val, {16'h0000, `CMT_YUV_O1});
		reg_write(`CMT_ADDR_PRESET, 32'h1);
		@(posedge clk_i);
		check("preset wb", {blue_wb_ratio_o, red_wb_ratio_o}, 32'h2000_1000);
		frame();
		reg_read(`CMT_ADDR_STATUS);
		check("status", rd_val, 32'h10);
		reg_write(`CMT_ADDR_WB, 32'h1234_5678);
		@(posedge clk_i);
		check("wb write", {blue_wb_ratio_o, red_wb_ratio_o}, 32'h1234_5678);
		complete_run();
	end
endmodule

// ===== verif/gamma_stage_model.sv
// identity gamma stage standing outside the transform, prompt or three cycles slow
// assumes 8-bit pixels; slow_i only changes while the stage is empty
`timescale 1ns/100ps

module gamma_stage_model (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       slow_i,
	input  wire logic       valid_i,
	input  wire logic [23:0] pix_i,
	output logic            valid_o,
	output logic [23:0]     pix_o
);
	logic [24:0] dly_reg [3];
	logic [24:0] pick;

	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
			dly_reg <= '{default: '0};
		else
			dly_reg <= '{{valid_i, pix_i}, dly_reg[0], dly_reg[1]};

	// pixels come back in order, one per clock
	assign pick = slow_i ? dly_reg[2] : {valid_i, pix_i};
	assign valid_o = pick[24];
	// idle lines carry a changing pattern so stale data cannot pass
	assign pix_o = pick[24] ? pick[23:0] : ~pick[23:0];
endmodule
